// >>> verilog/ftrs_cfg.svh
// constants for the fault trip and reset supervisor
// assumes a 40 mhz system clock
`ifndef FTRS_CFG_SVH
`define FTRS_CFG_SVH
`define FTRS_CLK_HZ          40000000
`define FTRS_RES_MIN_MS      100
`define FTRS_RECOVER_MS      1000
`define FTRS_FLASH_MS        250
`define FTRS_HIST_DEPTH      8
`define FTRS_CODE_OC_ACC     8'h10
`define FTRS_CODE_OC_STD     8'h11
`define FTRS_CODE_OC_DEC     8'h12
`define FTRS_CODE_OV_ACC     8'h20
`define FTRS_CODE_OV_STD     8'h21
`define FTRS_CODE_OV_DEC     8'h22
`define FTRS_CODE_NONE       8'h00
`define FTRS_ERASE_VALUE     8'h01
`define FTRS_DONE_MS         500
// register offsets (word addresses)
`define FTRS_REG_CTRL        4'h0
`define FTRS_REG_STATUS      4'h1
`define FTRS_REG_FAULT_CODE  4'h2
`define FTRS_REG_IRQ_STATUS  4'h3
`define FTRS_REG_IRQ_MASK    4'h4
`define FTRS_REG_HIST_SEL    4'h5
`define FTRS_REG_HIST_DATA   4'h6
`define FTRS_REG_ERASE       4'h7
// ctrl bits
`define FTRS_CTRL_ALARM_EN   0
// irq bits
`define FTRS_IRQ_TRIP        0
`define FTRS_IRQ_WARN        1
`define FTRS_IRQ_ALARM       2
`define FTRS_IRQ_RESET       3
`endif

// >>> verilog/ftrs_pkg.sv
// types for the fault trip and reset supervisor
// assumes ftrs_cfg.svh holds the numeric constants
package ftrs_pkg;
  typedef enum logic [1:0]
  {
    FTRS_RUN     = 2'b00,
    FTRS_TRIP    = 2'b01,
    FTRS_HOLD    = 2'b10,
    FTRS_RECOVER = 2'b11
  } ftrs_state_t;
  typedef enum logic [1:0]
  {
    FTRS_VIEW_MONITOR = 2'b00,
    FTRS_VIEW_FAULT   = 2'b01,
    FTRS_VIEW_ALARM   = 2'b10,
    FTRS_VIEW_RESET   = 2'b11
  } ftrs_view_t;
endpackage : ftrs_pkg

// >>> verilog/ftrs_supervisor.sv
// fault trip and reset supervisor: trip, fault code, history, reset paths, avalon-mm registers
// assumes fault inputs synchronous to clk; ext_clear_input and panel key are pins (synchronised here)
// Behaviour
// - writing 1 to erase parameter clears history
// - fault trips, stops output, asserts fault signal
// - output stays stopped until a reset
// - warnings only indicate, never trip
// - alarms never trip; optional alarm output
// - panel error messages shown without trip
// - display switches to fault or alarm view
// - any reset clears heat model and retries
// - operational again about 1s after reset
// - reset held keeps reset with flashing indication
// - stop key resets only during fault trip
// - history keeps last eight faults
// - overcurrent codes 0x10, 0x11, 0x12
// - overvoltage codes 0x20, 0x21, 0x22
// - warnings never produce a fault code
`timescale 1ns/1ps
`include "ftrs_cfg.svh"
module ftrs_supervisor #(
  parameter int RES_MIN_CYC  = `FTRS_CLK_HZ / 1000 * `FTRS_RES_MIN_MS + 1,
  parameter int RECOVER_CYC  = `FTRS_CLK_HZ / 1000 * `FTRS_RECOVER_MS,
  parameter int FLASH_CYC    = `FTRS_CLK_HZ / 1000 * `FTRS_FLASH_MS,
  parameter int DONE_CYC     = `FTRS_CLK_HZ / 1000 * `FTRS_DONE_MS,
  parameter int HIST_DEPTH   = `FTRS_HIST_DEPTH
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        overcurrent_accel_fault,
  input  wire logic        overcurrent_steady_fault,
  input  wire logic        overcurrent_decel_fault,
  input  wire logic        regen_overvoltage_accel_fault,
  input  wire logic        regen_overvoltage_steady_fault,
  input  wire logic        regen_overvoltage_decel_fault,
  input  wire logic        heat_model_prewarning,
  input  wire logic        warning_in,
  input  wire logic        alarm_in,
  input  wire logic        panel_error_in,
  input  wire logic        ext_clear_input,
  input  wire logic        panel_stop_key,
  output logic             output_enable,
  output logic             fault_out,
  output logic             alarm_out,
  output logic             warning_ind,
  output logic             panel_error_ind,
  output logic      [7:0]  fault_code,
  output ftrs_pkg::ftrs_view_t display_view,
  output logic             reset_flash,
  output logic             erase_done,
  output logic             heat_clear,
  output logic             retry_clear,
  output logic             irq
);
  localparam int HW = $clog2(HIST_DEPTH);

  function automatic logic [7:0] fault_encode(input logic [5:0] f);
    logic [7:0] c;
    c = `FTRS_CODE_NONE;
    if (f[0]) c = `FTRS_CODE_OC_ACC;
    else if (f[1]) c = `FTRS_CODE_OC_STD;
    else if (f[2]) c = `FTRS_CODE_OC_DEC;
    else if (f[3]) c = `FTRS_CODE_OV_ACC;
    else if (f[4]) c = `FTRS_CODE_OV_STD;
    else if (f[5]) c = `FTRS_CODE_OV_DEC;
    return c;
  endfunction : fault_encode

  ftrs_pkg::ftrs_state_t state;
  logic [1:0]  res_sync;
  logic [1:0]  key_sync;
  logic        key_prev;
  logic [31:0] res_cnt;
  logic [31:0] rec_cnt;
  logic [31:0] flash_cnt;
  logic [31:0] done_cnt;
  logic        res_ok;
  logic        alarm_en;
  logic [3:0]  irq_status;
  logic [3:0]  irq_mask;
  logic [HW-1:0] hist_sel;
  logic [HW-1:0] hist_wp;
  logic [7:0]  hist [HIST_DEPTH];
  logic        warn_prev;
  logic        alarm_prev;
  logic [5:0]  faults;
  logic        fault_any;
  logic        key_press;
  logic        res_level;
  logic        accept;
  logic        bus_wr;
  logic        bus_rd;
  logic        erase_wr;
  logic [3:0]  irq_ev;
  logic        rd_valid;

  assign faults    = {regen_overvoltage_decel_fault, regen_overvoltage_steady_fault,
                      regen_overvoltage_accel_fault, overcurrent_decel_fault,
                      overcurrent_steady_fault, overcurrent_accel_fault};
  assign fault_any = |faults;
  assign res_level = res_sync[1];
  assign key_press = key_sync[1] & ~key_prev;
  assign bus_wr    = avs_write & clk_en;
  assign bus_rd    = avs_read & clk_en;
  assign erase_wr  = bus_wr && avs_address == `FTRS_REG_ERASE && avs_byteenable[0]
                     && avs_writedata[7:0] == `FTRS_ERASE_VALUE;
  // stop key only counts during a trip; reset pin accepted past its minimum hold
  assign accept    = (state == ftrs_pkg::FTRS_TRIP && key_press)
                     || (state == ftrs_pkg::FTRS_HOLD && !res_level && res_ok);

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      res_sync <= 2'b00;
      key_sync <= 2'b00;
      key_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      res_sync <= {res_sync[0], ext_clear_input};
      key_sync <= {key_sync[0], panel_stop_key};
      key_prev <= key_sync[1];
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
      res_cnt <= 32'h0;
    else if (clk_en)
    begin
      if (!res_level)
        res_cnt <= 32'h0;
      else if (res_cnt < RES_MIN_CYC)
        res_cnt <= res_cnt + 32'h1;
    end
  assign res_ok = (res_cnt >= RES_MIN_CYC);

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      state   <= ftrs_pkg::FTRS_RUN;
      rec_cnt <= 32'h0;
    end
    else if (clk_en)
    begin
      case (state)
        ftrs_pkg::FTRS_RUN:
          if (res_level)
            state <= ftrs_pkg::FTRS_HOLD;
          else if (fault_any)
            state <= ftrs_pkg::FTRS_TRIP;
        ftrs_pkg::FTRS_TRIP:
          if (res_level)
            state <= ftrs_pkg::FTRS_HOLD;
          else if (accept)
          begin
            state   <= ftrs_pkg::FTRS_RECOVER;
            rec_cnt <= 32'h0;
          end
        ftrs_pkg::FTRS_HOLD:
          if (accept)
          begin
            state   <= ftrs_pkg::FTRS_RECOVER;
            rec_cnt <= 32'h0;
          end
          else if (!res_level)
            state <= (fault_code != `FTRS_CODE_NONE) ? ftrs_pkg::FTRS_TRIP : ftrs_pkg::FTRS_RUN;
        ftrs_pkg::FTRS_RECOVER:
          if (res_level)
            state <= ftrs_pkg::FTRS_HOLD;
          else if (rec_cnt >= RECOVER_CYC - 1)
            state <= ftrs_pkg::FTRS_RUN;
          else
            rec_cnt <= rec_cnt + 32'h1;
        default:
          state <= ftrs_pkg::FTRS_RUN;
      endcase
    end

  // output stays off outside run
  assign output_enable = (state == ftrs_pkg::FTRS_RUN) && !fault_any;
  assign heat_clear    = accept;
  assign retry_clear   = accept;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      fault_code <= `FTRS_CODE_NONE;
      fault_out  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (accept)
      begin
        fault_code <= `FTRS_CODE_NONE;
        fault_out  <= 1'b0;
      end
      else if (state == ftrs_pkg::FTRS_RUN && fault_any && !res_level)
      begin
        fault_code <= fault_encode(faults);
        fault_out  <= 1'b1;
      end
    end

  // history ring of last faults
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      hist_wp <= '0;
      for (int i = 0; i < HIST_DEPTH; i++)
        hist[i] <= `FTRS_CODE_NONE;
    end
    else if (clk_en)
    begin
      if (erase_wr)
      begin
        hist_wp <= '0;
        for (int i = 0; i < HIST_DEPTH; i++)
          hist[i] <= `FTRS_CODE_NONE;
      end
      else if (state == ftrs_pkg::FTRS_RUN && fault_any && !res_level)
      begin
        hist[hist_wp] <= fault_encode(faults);
        hist_wp       <= hist_wp + 1'b1;
      end
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      done_cnt   <= 32'h0;
      erase_done <= 1'b0;
    end
    else if (clk_en)
    begin
      if (erase_wr)
      begin
        done_cnt   <= 32'h0;
        erase_done <= 1'b1;
      end
      else if (erase_done)
      begin
        if (done_cnt >= DONE_CYC - 1)
          erase_done <= 1'b0;
        else
          done_cnt <= done_cnt + 32'h1;
      end
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      flash_cnt   <= 32'h0;
      reset_flash <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state != ftrs_pkg::FTRS_HOLD)
      begin
        flash_cnt   <= 32'h0;
        reset_flash <= 1'b0;
      end
      else if (flash_cnt >= FLASH_CYC - 1)
      begin
        flash_cnt   <= 32'h0;
        reset_flash <= ~reset_flash;
      end
      else
        flash_cnt <= flash_cnt + 32'h1;
    end

  // indications never touch the trip path
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      warning_ind     <= 1'b0;
      panel_error_ind <= 1'b0;
      alarm_out       <= 1'b0;
      warn_prev       <= 1'b0;
      alarm_prev      <= 1'b0;
    end
    else if (clk_en)
    begin
      warning_ind     <= warning_in | heat_model_prewarning;
      panel_error_ind <= panel_error_in;
      alarm_out       <= alarm_in & alarm_en;
      warn_prev       <= warning_in | heat_model_prewarning;
      alarm_prev      <= alarm_in;
    end

  always_ff @(posedge clk or posedge rst)
    if (rst)
      display_view <= ftrs_pkg::FTRS_VIEW_MONITOR;
    else if (clk_en)
    begin
      if (state == ftrs_pkg::FTRS_HOLD)
        display_view <= ftrs_pkg::FTRS_VIEW_RESET;
      else if (fault_out || (state == ftrs_pkg::FTRS_RUN && fault_any))
        display_view <= ftrs_pkg::FTRS_VIEW_FAULT;
      else if (alarm_in)
        display_view <= ftrs_pkg::FTRS_VIEW_ALARM;
      else
        display_view <= ftrs_pkg::FTRS_VIEW_MONITOR;
    end

  // interrupt events
  assign irq_ev[`FTRS_IRQ_TRIP]  = state == ftrs_pkg::FTRS_RUN && fault_any && !res_level;
  assign irq_ev[`FTRS_IRQ_WARN]  = (warning_in | heat_model_prewarning) & ~warn_prev;
  assign irq_ev[`FTRS_IRQ_ALARM] = alarm_in & ~alarm_prev;
  assign irq_ev[`FTRS_IRQ_RESET] = accept;

  always_ff @(posedge clk or posedge rst)
    if (rst)
      irq_status <= 4'h0;
    else if (clk_en)
    begin
      if (bus_rd && !rd_valid && avs_address == `FTRS_REG_IRQ_STATUS)
        irq_status <= irq_ev;
      else
        irq_status <= irq_status | irq_ev;
    end
  assign irq = |(irq_status & irq_mask);

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      alarm_en <= 1'b0;
      irq_mask <= 4'h0;
      hist_sel <= '0;
    end
    else if (bus_wr && avs_byteenable[0])
    begin
      case (avs_address)
        `FTRS_REG_CTRL:     alarm_en <= avs_writedata[`FTRS_CTRL_ALARM_EN];
        `FTRS_REG_IRQ_MASK: irq_mask <= avs_writedata[3:0];
        `FTRS_REG_HIST_SEL: hist_sel <= avs_writedata[HW-1:0];
        default:            ;
      endcase
    end

  // reads wait one cycle so read data comes from a flop
  assign avs_waitrequest = avs_read & ~rd_valid;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rd_valid     <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else if (clk_en)
    begin
      rd_valid <= bus_rd & ~rd_valid;
      if (bus_rd && !rd_valid)
        case (avs_address)
          `FTRS_REG_CTRL:       avs_readdata <= {31'h0, alarm_en};
          `FTRS_REG_STATUS:     avs_readdata <= {26'h0, reset_flash, erase_done, alarm_out, warning_ind, fault_out,
                                                 output_enable};
          `FTRS_REG_FAULT_CODE: avs_readdata <= {24'h0, fault_code};
          `FTRS_REG_IRQ_STATUS: avs_readdata <= {28'h0, irq_status};
          `FTRS_REG_IRQ_MASK:   avs_readdata <= {28'h0, irq_mask};
          `FTRS_REG_HIST_SEL:   avs_readdata <= 32'(hist_sel);
          `FTRS_REG_HIST_DATA:  avs_readdata <= {24'h0, hist[hist_sel]};
          default:              avs_readdata <= 32'h0;
        endcase
    end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_trip_out; clk_en && irq_ev[`FTRS_IRQ_TRIP] |=> fault_out && !output_enable; endproperty
  a_trip_out: assert property (p_trip_out) else $error("trip did not stop output");
  property p_stay_off; state == ftrs_pkg::FTRS_TRIP |-> !output_enable; endproperty
  a_stay_off: assert property (p_stay_off) else $error("output on during trip");
  property p_warn_quiet; clk_en && state == ftrs_pkg::FTRS_RUN && !fault_any && !res_level |=> !fault_out; endproperty
  a_warn_quiet: assert property (p_warn_quiet) else $error("fault without fault input");
  property p_alarm_gate; clk_en |=> alarm_out == $past(alarm_in & alarm_en); endproperty
  a_alarm_gate: assert property (p_alarm_gate) else $error("alarm output not gated");
  property p_code_hold; state == ftrs_pkg::FTRS_TRIP && !accept |=> $stable(fault_code); endproperty
  a_code_hold: assert property (p_code_hold) else $error("fault code changed in trip");
  property p_view_reset; clk_en && state == ftrs_pkg::FTRS_HOLD |=> display_view == ftrs_pkg::FTRS_VIEW_RESET; endproperty
  a_view_reset: assert property (p_view_reset) else $error("reset view missing");
  property p_idle_key; key_press && state != ftrs_pkg::FTRS_TRIP && state != ftrs_pkg::FTRS_HOLD |-> !heat_clear; endproperty
  a_idle_key: assert property (p_idle_key) else $error("stop key reset outside trip");
  c_trip: cover property (clk_en && irq_ev[`FTRS_IRQ_TRIP]);
  c_key_reset: cover property (state == ftrs_pkg::FTRS_TRIP && accept);
  c_erase: cover property (erase_wr);
endmodule : ftrs_supervisor

// >>> sim/ftrs_panel_model.sv
// operator panel stop key and external clear source
// assumes the bench calls its tasks from the clk domain
`timescale 1ns/1ps
module ftrs_panel_model
(
  input  wire logic clk,
  output logic      ext_clear_input,
  output logic      panel_stop_key
);
  initial
  begin
    ext_clear_input = 1'b0;
    panel_stop_key  = 1'b0;
  end
  task set_clear(input logic v);
    @(posedge clk);
    ext_clear_input <= v;
  endtask : set_clear
  // hold the clear line for n cycles
  task hold_clear(input int n);
    set_clear(1'b1);
    repeat (n) @(posedge clk);
    ext_clear_input <= 1'b0;
  endtask : hold_clear
  task press_stop;
    @(posedge clk);
    panel_stop_key <= 1'b1;
    @(posedge clk);
    panel_stop_key <= 1'b0;
  endtask : press_stop
endmodule : ftrs_panel_model

// >>> sim/tb_ftrs_supervisor.sv
// directed bench for the fault trip and reset supervisor
// assumes short count parameters and avalon-mm register access
`timescale 1ns/1ps
`include "ftrs_cfg.svh"
module tb_ftrs_supervisor;
  localparam int RMIN = 20;
  localparam int RCV  = 40;
  logic clk = 0, rst = 1, rd = 0, wr = 0, hw = 0, wn = 0, al = 0, pe = 0;
  logic [3:0]  addr = 0;
  logic        ce = 1;
  logic [3:0]  be = 4'hf;
  logic [31:0] wdata = 0, rdata, q;
  logic [5:0]  flt = 0;
  logic waitreq, oe, fo, ao, wi, pi, rf, ed, hc, rc, irq, xclr, stop;
  logic [7:0]  code;
  ftrs_pkg::ftrs_view_t view;
  int errors = 0, n_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  ftrs_panel_model m (.clk(clk), .ext_clear_input(xclr), .panel_stop_key(stop));
  ftrs_supervisor #(.RES_MIN_CYC(RMIN), .RECOVER_CYC(RCV), .FLASH_CYC(8), .DONE_CYC(10), .HIST_DEPTH(8)) uut (
    .clk(clk), .rst(rst), .clk_en(ce), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .overcurrent_accel_fault(flt[0]), .overcurrent_steady_fault(flt[1]), .overcurrent_decel_fault(flt[2]),
    .regen_overvoltage_accel_fault(flt[3]), .regen_overvoltage_steady_fault(flt[4]),
    .regen_overvoltage_decel_fault(flt[5]), .heat_model_prewarning(hw), .warning_in(wn), .alarm_in(al),
    .panel_error_in(pe), .ext_clear_input(xclr), .panel_stop_key(stop), .output_enable(oe), .fault_out(fo),
    .alarm_out(ao), .warning_ind(wi), .panel_error_ind(pi), .fault_code(code), .display_view(view),
    .reset_flash(rf), .erase_done(ed), .heat_clear(hc), .retry_clear(rc), .irq(irq));
  task summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      summarize;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function logic pick(input int s);
    case (s)
      0: return oe;
      1: return fo;
      2: return hc;
      3: return rf;
      default: return ed;
    endcase
  endfunction : pick
  task wt(input int s, input logic v, input int lim);
    int k;
    k = 0;
    while (pick(s) !== v && k < lim)
    begin
      @(negedge clk);
      k++;
    end
    chk(32'(pick(s)), 32'(v));
  endtask : wt
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge clk);
  endtask : bus
  task trip(input int i);
    @(posedge clk);
    flt <= 6'h1 << i;
    @(posedge clk);
    flt <= 6'h0;
    wt(1, 1'b1, 50);
    repeat (2) @(negedge clk);
  endtask : trip
  task clr;
    m.press_stop;
    wt(0, 1'b1, RCV + 80);
  endtask : clr
  task t_codes;
    logic [7:0] c [6];
    c = '{8'h10, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22};
    bus(1'b1, `FTRS_REG_IRQ_MASK, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      trip(i);
      chk(oe, 0);
      chk(code, c[i]);
      chk(view, ftrs_pkg::FTRS_VIEW_FAULT);
      chk(irq, i == 0);
      if (i == 0)
      begin
        bus(1'b0, `FTRS_REG_IRQ_STATUS, 32'h0);
        chk(q[`FTRS_IRQ_TRIP], 1);
        chk(irq, 0);
        bus(1'b1, `FTRS_REG_IRQ_MASK, 32'h0);
      end
      repeat (30) @(negedge clk);
      chk(oe, 0);
      chk(code, c[i]);
      m.press_stop;
      wt(2, 1'b1, 50);
      chk(rc, 1);
      wt(0, 1'b1, RCV + 60);
      chk(code, 0);
    end
  endtask : t_codes
  task t_quiet;
    bus(1'b1, `FTRS_REG_CTRL, 32'h1);
    @(posedge clk);
    {hw, wn, al, pe} <= 4'hf;
    repeat (20) @(negedge clk);
    chk(oe, 1);
    chk(fo, 0);
    chk(code, 0);
    chk(ao, 1);
    chk(wi, 1);
    chk(pi, 1);
    chk(view, ftrs_pkg::FTRS_VIEW_ALARM);
    @(posedge clk);
    {hw, wn, pe} <= 3'h0;
    bus(1'b1, `FTRS_REG_CTRL, 32'h0);
    repeat (5) @(negedge clk);
    chk(ao, 0);
    @(posedge clk);
    al <= 1'b0;
    bus(1'b0, 4'hf, 32'h0);
  endtask : t_quiet
  task t_idle_stop;
    logic s;
    s = 1'b0;
    m.press_stop;
    repeat (30)
    begin
      @(negedge clk);
      s = s | hc | !oe;
    end
    chk(s, 0);
  endtask : t_idle_stop
  task t_freeze;
    @(posedge clk);
    ce  <= 1'b0;
    flt <= 6'h1;
    repeat (5) @(negedge clk);
    chk(fo, 0);
    @(posedge clk);
    flt <= 6'h0;
    ce  <= 1'b1;
    be  <= 4'h0;
    bus(1'b1, `FTRS_REG_IRQ_MASK, 32'hf);
    @(posedge clk);
    be <= 4'hf;
    bus(1'b0, `FTRS_REG_IRQ_MASK, 32'h0);
    chk(q, 0);
    chk(fo, 0);
    bus(1'b0, `FTRS_REG_FAULT_CODE, 32'h0);
    chk(q, 0);
  endtask : t_freeze
  task t_ext;
    trip(0);
    m.hold_clear(RMIN - 8);
    repeat (20) @(negedge clk);
    chk(fo, 1);
    m.set_clear(1'b1);
    wt(3, 1'b1, RMIN + 60);
    chk(oe, 0);
    repeat (RMIN) @(posedge clk);
    m.set_clear(1'b0);
    repeat (RCV / 2) @(negedge clk);
    chk(oe, 0);
    wt(0, 1'b1, RCV + 60);
  endtask : t_ext
  task t_hist;
    trip(4);
    clr;
    trip(3);
    clr;
    bus(1'b1, `FTRS_REG_HIST_SEL, 32'h0);
    bus(1'b0, `FTRS_REG_HIST_DATA, 32'h0);
    chk(q[7:0], 8'h20);
    bus(1'b1, `FTRS_REG_HIST_SEL, 32'h7);
    bus(1'b0, `FTRS_REG_HIST_DATA, 32'h0);
    chk(q[7:0], 8'h21);
    bus(1'b1, `FTRS_REG_ERASE, 32'(`FTRS_ERASE_VALUE));
    wt(4, 1'b1, 40);
    bus(1'b1, `FTRS_REG_HIST_SEL, 32'h0);
    bus(1'b0, `FTRS_REG_HIST_DATA, 32'h0);
    chk(q[7:0], 8'h00);
  endtask : t_hist
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_codes;
    t_quiet;
    t_idle_stop;
    t_freeze;
    t_ext;
    t_hist;
    summarize;
  end
endmodule : tb_ftrs_supervisor
